// *** hw/pwmdb_cfg.svh ***
`ifndef PWMDB_CFG_SVH
`define PWMDB_CFG_SVH
// register word addresses on the wishbone bus (byte addresses, one word each)
`define PWMDB_ADDR_DELAY     4'h0
`define PWMDB_ADDR_SHUTDOWN  4'h4
`define PWMDB_ADDR_CONTROL   4'h8
`define PWMDB_ADDR_STATUS    4'hC
// field positions
`define PWMDB_RESTART_BIT    7
`define PWMDB_STATUS_BIT     7
`define PWMDB_SRC_HI         6
`define PWMDB_SRC_LO         4
`define PWMDB_AC_HI          3
`define PWMDB_AC_LO          2
`define PWMDB_BD_HI          1
`define PWMDB_BD_LO          0
`define PWMDB_CNT_HI         6
`define PWMDB_POL_AC_BIT     0
`define PWMDB_POL_BD_BIT     1
`define PWMDB_CFG_LO         2
`define PWMDB_CFG_HI         3
// reset values
`define PWMDB_DELAY_RST      8'h00
`define PWMDB_SHUTDOWN_RST   8'h00
`define PWMDB_CONTROL_RST    8'h00
// instruction cycle is four oscillator periods; core clock equals oscillator
`define PWMDB_TCY_TOSC       4
`define PWMDB_TCY_DIV_W      2
`endif

// *** hw/pwmdb_deadband.sv ***
`timescale 1ns/1ps
`include "pwmdb_cfg.svh"
module pwmdb_deadband
   import pwmdb_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       tcy_en,
   input  wire logic       hold_clr,
   input  wire logic [6:0] delay_count,
   input  wire logic       sched_act,
   output logic            delayed_act
);
   typedef enum logic [1:0] {
      PWMDB_DB_IDLE = 2'b01,
      PWMDB_DB_WAIT = 2'b10
   } pwmdb_db_state_t;

   pwmdb_db_state_t state_ff;
   logic [6:0]      cnt_ff;
   logic            act_ff;

   assign delayed_act = act_ff;

   // inactive-to-active edges are delayed, deactivation is immediate
   always_ff @(posedge core_clk) begin
      if (srst || hold_clr) begin
         state_ff <= PWMDB_DB_IDLE;
         cnt_ff   <= 7'h00;
         act_ff   <= 1'b0;
      end else if (!sched_act) begin
         state_ff <= PWMDB_DB_IDLE;
         cnt_ff   <= 7'h00;
         act_ff   <= 1'b0;
      end else begin
         case (state_ff)
            PWMDB_DB_IDLE: begin
               if (!act_ff) begin
                  if (delay_count == 7'h00) begin
                     act_ff <= 1'b1;
                  end else begin
                     state_ff <= PWMDB_DB_WAIT;
                     cnt_ff   <= delay_count;
                  end
               end
            end
            PWMDB_DB_WAIT: begin
               // a delay longer than the active time never fires: stays low all cycle
               if (tcy_en) begin
                  if (cnt_ff == 7'h01) begin
                     act_ff   <= 1'b1;
                     state_ff <= PWMDB_DB_IDLE;
                  end
                  cnt_ff <= cnt_ff - 7'h01;
               end
            end
            default: state_ff <= PWMDB_DB_IDLE;
         endcase
      end
   end

   AST_DB_FALL_NOW: assert property (@(posedge core_clk) disable iff (srst)
      !sched_act |=> !act_ff)
      else $error("activity not dropped at once");
endmodule

// *** hw/pwmdb_pkg.sv ***
package pwmdb_pkg;
   typedef enum logic [1:0] {
      PWMDB_CFG_SINGLE = 2'h0,
      PWMDB_CFG_HALF   = 2'h1,
      PWMDB_CFG_FULL_F = 2'h2,
      PWMDB_CFG_FULL_R = 2'h3
   } pwmdb_cfg_t;

   // per-pin drive: value and output enable
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oe;
   } pwmdb_pins_t;

   typedef struct packed {
      logic       cmp1;
      logic       cmp2;
      logic       pin_low;
   } pwmdb_src_t;
endpackage

// *** hw/pwmdb_top.sv ***
`timescale 1ns/1ps
`include "pwmdb_cfg.svh"
// How it works
// - dead-band delays only the inactive-to-active transition in half-bridge mode
// - delay equals delay_count instruction cycles of four oscillator periods
// - any enhanced configuration plus selected event forces shutdown pin levels
// - three-bit source select picks comparators and pin combinations
// - low level on external shutdown pin is a shutdown event
// - shutdown levels appear on the third clock edge after the event, without waiting for period
// - pair A/C shutdown state: 00 low, 01 high, 1x high impedance
// - pair B/D shutdown state: 00 low, 01 high, 1x high impedance
// - hardware sets shutdown_status on event; outputs held while set
// - status set at period start keeps shutdown whole period
// - normal output resumes only at next period start after clear
// - restart_enable clears status automatically when cause goes away
// - without restart_enable status stays set until software clears it
// - software writes to status ignored while shutdown condition active
// - comparator sources act as levels; status holds while they persist
// - writing one to status forces shutdown without an event
// - two polarity bits choose active level for each output pair
// - power-on clears all three registers; other resets clear shutdown and control, not delay
// - half-bridge drives PWM on A and complement on B
// - delay longer than duty keeps that output inactive whole cycle
module pwmdb_top
   import pwmdb_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        por,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        period_start,
   input  wire logic        pwm_raw,
   input  wire logic [3:0]  pwm_full_raw,
   input  wire logic        cmp1_out,
   input  wire logic        cmp2_out,
   input  wire logic        external_shutdown_pin,
   output logic [3:0]       pwm_out_val_ff,
   output logic [3:0]       pwm_out_oe_ff
);
   logic [7:0]      delay_ff;
   logic [6:0]      shut_cfg_ff;
   logic [7:0]      control_ff;
   logic            asd_wr;
   logic            asd_wdata;
   logic [7:0]      status_rd;
   logic            pin_s1_ff;
   logic            pin_s2_ff;
   logic            cmp1_s1_ff;
   logic            cmp1_s2_ff;
   logic            cmp2_s1_ff;
   logic            cmp2_s2_ff;
   logic            shutdown_status_ff;
   logic            period_hold_ff;
   logic [1:0]      tcy_div_ff;
   logic            tcy_en;
   logic            cause;
   logic            act_a;
   logic            act_b;
   logic            enhanced;
   pwmdb_src_t      src;
   pwmdb_cfg_t      cfg;
   pwmdb_pins_t     nxt_pins;
   logic [1:0]      pol;

   pwmdb_wb_regs u_regs (
      .core_clk    (core_clk),
      .srst        (srst),
      .por         (por),
      .wb_cyc_i    (wb_cyc_i),
      .wb_stb_i    (wb_stb_i),
      .wb_we_i     (wb_we_i),
      .wb_adr_i    (wb_adr_i),
      .wb_sel_i    (wb_sel_i),
      .wb_dat_i    (wb_dat_i),
      .status_rd   (status_rd),
      .wb_dat_o    (wb_dat_o),
      .wb_ack_o    (wb_ack_o),
      .delay_ff    (delay_ff),
      .shut_cfg_ff (shut_cfg_ff),
      .control_ff  (control_ff),
      .asd_wr      (asd_wr),
      .asd_wdata   (asd_wdata)
   );

   // source selection decode, used for the status path and the read-back
   function automatic logic sel_cause(input logic [2:0] sel, input pwmdb_src_t s);
      sel_cause = (sel[0] && s.cmp1) || (sel[1] && s.cmp2) || (sel[2] && s.pin_low);
   endfunction

   // pins and comparators come from outside this clock domain
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_s1_ff  <= 1'b1;
         pin_s2_ff  <= 1'b1;
         cmp1_s1_ff <= 1'b0;
         cmp1_s2_ff <= 1'b0;
         cmp2_s1_ff <= 1'b0;
         cmp2_s2_ff <= 1'b0;
      end else begin
         pin_s1_ff  <= external_shutdown_pin;
         pin_s2_ff  <= pin_s1_ff;
         cmp1_s1_ff <= cmp1_out;
         cmp1_s2_ff <= cmp1_s1_ff;
         cmp2_s1_ff <= cmp2_out;
         cmp2_s2_ff <= cmp2_s1_ff;
      end
   end

   assign src.cmp1    = cmp1_s2_ff;
   assign src.cmp2    = cmp2_s2_ff;
   assign src.pin_low = !pin_s2_ff;
   assign cause       = sel_cause(shut_cfg_ff[6:4], src);
   assign cfg         = pwmdb_cfg_t'(control_ff[`PWMDB_CFG_HI:`PWMDB_CFG_LO]);
   assign pol         = control_ff[1:0];
   assign enhanced    = cfg != PWMDB_CFG_SINGLE;
   assign status_rd   = {shutdown_status_ff, 3'h0, period_hold_ff, cause, 2'h0};

   // instruction-cycle enable: one pulse every four core clocks
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tcy_div_ff <= 2'h0;
      end else begin
         tcy_div_ff <= tcy_div_ff + 2'h1;
      end
   end
   assign tcy_en = tcy_div_ff == 2'h3;

   // set beats every clear; a write is ignored while the cause persists
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shutdown_status_ff <= 1'b0;
      end else if (cause && enhanced) begin
         shutdown_status_ff <= 1'b1;
      end else if (asd_wr && !cause) begin
         shutdown_status_ff <= asd_wdata;
      end else if (delay_ff[`PWMDB_RESTART_BIT] && !cause) begin
         shutdown_status_ff <= 1'b0;
      end
   end

   // hold remains until a period boundary sees the status clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         period_hold_ff <= 1'b0;
      end else if (shutdown_status_ff || (cause && enhanced)) begin
         period_hold_ff <= 1'b1;
      end else if (period_start) begin
         period_hold_ff <= 1'b0;
      end
   end

   pwmdb_deadband u_db_a (
      .core_clk    (core_clk),
      .srst        (srst),
      .tcy_en      (tcy_en),
      .hold_clr    (period_hold_ff),
      .delay_count (delay_ff[`PWMDB_CNT_HI:0]),
      .sched_act   (pwm_raw),
      .delayed_act (act_a)
   );

   pwmdb_deadband u_db_b (
      .core_clk    (core_clk),
      .srst        (srst),
      .tcy_en      (tcy_en),
      .hold_clr    (period_hold_ff),
      .delay_count (delay_ff[`PWMDB_CNT_HI:0]),
      .sched_act   (!pwm_raw),
      .delayed_act (act_b)
   );

   // outputs pass through one flop; shutdown is applied on the very next edge
   // from the synchronised event, the closest a single-clock design gets to async
   always_comb begin
      logic [3:0] active;
      active   = 4'h0;
      nxt_pins = '0;
      case (cfg)
         PWMDB_CFG_HALF: active = {1'b0, 1'b0, act_b, act_a};
         default:        active = (cfg == PWMDB_CFG_SINGLE) ? {3'h0, pwm_raw} : pwm_full_raw;
      endcase
      nxt_pins.oe  = 4'hF;
      // a set polarity bit makes that pair active low
      nxt_pins.val = active ^ {pol[1], pol[0], pol[1], pol[0]};
      if (enhanced && (period_hold_ff || shutdown_status_ff || cause)) begin
         nxt_pins.val = {shut_cfg_ff[`PWMDB_BD_LO], shut_cfg_ff[`PWMDB_AC_LO],
                         shut_cfg_ff[`PWMDB_BD_LO], shut_cfg_ff[`PWMDB_AC_LO]};
         nxt_pins.oe  = {!shut_cfg_ff[`PWMDB_BD_HI], !shut_cfg_ff[`PWMDB_AC_HI],
                         !shut_cfg_ff[`PWMDB_BD_HI], !shut_cfg_ff[`PWMDB_AC_HI]};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pwm_out_val_ff <= 4'h0;
         pwm_out_oe_ff  <= 4'h0;
      end else begin
         pwm_out_val_ff <= nxt_pins.val;
         pwm_out_oe_ff  <= nxt_pins.oe;
      end
   end

   AST_SET_ON_CAUSE: assert property (@(posedge core_clk) disable iff (srst)
      (cause && enhanced) |=> shutdown_status_ff)
      else $error("status not set by event");
   AST_HOLD_LEVELS: assert property (@(posedge core_clk) disable iff (srst)
      (enhanced && shutdown_status_ff && !shut_cfg_ff[3] && $stable(shut_cfg_ff))
      |=> pwm_out_oe_ff[0] && pwm_out_val_ff[0] == shut_cfg_ff[2])
      else $error("A pin not at shutdown level");
   AST_TRISTATE_BD: assert property (@(posedge core_clk) disable iff (srst)
      (enhanced && shutdown_status_ff && shut_cfg_ff[1] && $stable(shut_cfg_ff))
      |=> !pwm_out_oe_ff[1] && !pwm_out_oe_ff[3])
      else $error("B/D not released in shutdown");
   AST_WRITE_BLOCKED: assert property (@(posedge core_clk) disable iff (srst)
      (cause && asd_wr && shutdown_status_ff) |=> shutdown_status_ff)
      else $error("status cleared while cause active");
   AST_NO_MIDPERIOD: assert property (@(posedge core_clk) disable iff (srst)
      (period_hold_ff && !period_start) |=> period_hold_ff)
      else $error("output resumed mid period");
   AST_AUTO_RESTART: assert property (@(posedge core_clk) disable iff (srst)
      (shutdown_status_ff && !cause && delay_ff[7] && !asd_wr) |=> !shutdown_status_ff)
      else $error("auto restart missing");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (srst)
      (shutdown_status_ff && !delay_ff[7] && !asd_wr) |=> shutdown_status_ff)
      else $error("status cleared without software");
   AST_FORCE: assert property (@(posedge core_clk) disable iff (srst)
      (asd_wr && asd_wdata) |=> shutdown_status_ff)
      else $error("forced shutdown ignored");
   AST_PIN_LOW: assert property (@(posedge core_clk) disable iff (srst)
      (enhanced && shut_cfg_ff[6] && !external_shutdown_pin)[*3] |=> shutdown_status_ff)
      else $error("pin low did not shut down");

   COV_SHUTDOWN: cover property (@(posedge core_clk) $rose(shutdown_status_ff));
   COV_RESTART: cover property (@(posedge core_clk) $fell(period_hold_ff));
   COV_DB_FIRE: cover property (@(posedge core_clk) $rose(act_a) && delay_ff[6:0] != 7'h00);
endmodule

// *** hw/pwmdb_wb_regs.sv ***
`timescale 1ns/1ps
`include "pwmdb_cfg.svh"
module pwmdb_wb_regs
   import pwmdb_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        por,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [7:0]  status_rd,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic [7:0]       delay_ff,
   output logic [6:0]       shut_cfg_ff,
   output logic [7:0]       control_ff,
   output logic             asd_wr,
   output logic             asd_wdata
);
   logic req;
   logic wr_lane0;

   assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // the delay register survives every reset except power-on
   always_ff @(posedge core_clk) begin
      if (por) begin
         delay_ff <= `PWMDB_DELAY_RST;
      end else if (wr_lane0 && wb_adr_i == `PWMDB_ADDR_DELAY) begin
         delay_ff <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || por) begin
         shut_cfg_ff <= 7'h00;
         control_ff  <= `PWMDB_CONTROL_RST;
      end else if (wr_lane0 && wb_adr_i == `PWMDB_ADDR_SHUTDOWN) begin
         shut_cfg_ff <= wb_dat_i[6:0];
      end else if (wr_lane0 && wb_adr_i == `PWMDB_ADDR_CONTROL) begin
         control_ff <= wb_dat_i[7:0];
      end
   end

   always_comb begin
      asd_wr    = wr_lane0 && wb_adr_i == `PWMDB_ADDR_SHUTDOWN;
      asd_wdata = wb_dat_i[`PWMDB_STATUS_BIT];
   end

   // unmapped addresses ack with zero data
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            `PWMDB_ADDR_DELAY:    wb_dat_o <= {24'h000000, delay_ff};
            `PWMDB_ADDR_SHUTDOWN: wb_dat_o <= {24'h000000, status_rd[7], shut_cfg_ff};
            `PWMDB_ADDR_CONTROL:  wb_dat_o <= {24'h000000, control_ff};
            `PWMDB_ADDR_STATUS:   wb_dat_o <= {24'h000000, status_rd};
            default:              wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// *** verif/pwmdb_bridge_model.sv ***
`timescale 1ns/1ps
module pwmdb_bridge_model (
   input  wire logic       watch_en,
   input  wire logic [3:0] drv_val,
   input  wire logic [3:0] drv_oe,
   output logic [3:0]      pin_lvl,
   output logic            shoot_seen
);
   // a released pin falls to the external pull-down, which keeps its switch off
   assign pin_lvl = drv_oe & drv_val;
   initial shoot_seen = 1'b0;
   // upper and lower switch of the half bridge on together is a short
   always @(pin_lvl) begin
      if (watch_en && pin_lvl[0] && pin_lvl[1]) begin
         shoot_seen = 1'b1;
      end
   end
endmodule

// *** verif/pwmdb_top_tb_top.sv ***
`timescale 1ns/1ps
module pwmdb_top_tb_top;
   import pwmdb_pkg::*;
   logic        core_clk, srst, por, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0]  wb_adr_i, wb_sel_i, pwm_full_raw;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        wb_ack_o, period_start, pwm_raw, cmp1_out, cmp2_out;
   logic        external_shutdown_pin, watch_en, shoot_seen, hi;
   logic [3:0]  pwm_out_val_ff, pwm_out_oe_ff, pin_lvl, ac, bd;
   int          num_errors, cmp_count, n;

   pwmdb_top dut_u (.core_clk(core_clk), .srst(srst), .por(por), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .period_start(period_start), .pwm_raw(pwm_raw), .pwm_full_raw(pwm_full_raw),
      .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
      .external_shutdown_pin(external_shutdown_pin),
      .pwm_out_val_ff(pwm_out_val_ff), .pwm_out_oe_ff(pwm_out_oe_ff));
   pwmdb_bridge_model bridge_u (.watch_en(watch_en), .drv_val(pwm_out_val_ff),
      .drv_oe(pwm_out_oe_ff), .pin_lvl(pin_lvl), .shoot_seen(shoot_seen));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int hi_lim, input int got);
      cmp_count++;
      if (got < lo || got > hi_lim) begin
         num_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi_lim, got);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // classic single cycle: request held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [7:0] wd,
                          output logic [7:0] rd);
      int w;
      w = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, wd};
      do begin
         @(posedge core_clk);
         w++;
      end while (wb_ack_o !== 1'b1 && w < 50);
      if (w >= 50) begin
         num_errors++;
         $display("[FAIL] wb_ack expected 1 seen none");
      end
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] adr, input logic [7:0] d);
      logic [7:0] x;
      wb_xfer(1'b1, adr, d, x);
   endtask

   task automatic rdchk(input string name, input logic [3:0] adr, input logic [7:0] mask,
                        input logic [7:0] exp);
      logic [7:0] x;
      wb_xfer(1'b0, adr, 8'h00, x);
      chk(name, exp, x & mask);
   endtask

   task automatic pstart();
      @(posedge core_clk);
      period_start <= 1'b1;
      @(posedge core_clk);
      period_start <= 1'b0;
   endtask

   task automatic cause(input int c, input logic on);
      cmp1_out <= (c == 0) && on;
      cmp2_out <= (c == 1) && on;
      external_shutdown_pin <= !((c == 2) && on);
   endtask

   task automatic wait_lvl(input int idx, input logic lvl, inout int k);
      while (pwm_out_val_ff[idx] !== lvl && k < 700) begin
         @(posedge core_clk);
         k++;
      end
   endtask

   initial begin
      #1500000;
      num_errors++;
      wrap_up();
   end

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, period_start, pwm_raw, cmp1_out, cmp2_out} = 7'h00;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h00000000;
      pwm_full_raw = 4'h0;
      external_shutdown_pin = 1'b1;
      watch_en = 1'b1;
      num_errors = 0;
      cmp_count = 0;
      srst = 1'b1;
      por = 1'b1;
      cyc(3);
      srst <= 1'b0;
      por <= 1'b0;
      rdchk("delay_rst", 4'h0, 8'hFF, 8'h00);
      rdchk("shut_rst", 4'h4, 8'hFF, 8'h00);
      rdchk("unmapped", 4'h2, 8'hFF, 8'h00);
      wr(4'h0, 8'h05);
      wr(4'h8, 8'h04);
      wr(4'h4, 8'h80);
      pstart();
      pstart();
      cyc(4);
      chk("held_period", 8'hF0, {pwm_out_oe_ff, pwm_out_val_ff});
      wr(4'h4, 8'h00);
      pstart();
      cyc(30);
      chk("b_active", 8'h01, pwm_out_val_ff[1]);
      pwm_raw <= 1'b1;
      n = 0;
      wait_lvl(0, 1'b1, n);
      chk_rng("a_delay", 16, 24, n);
      chk("b_off", 8'h00, pwm_out_val_ff[1]);
      pwm_raw <= 1'b0;
      n = 0;
      wait_lvl(0, 1'b0, n);
      chk_rng("a_fall", 0, 3, n);
      wait_lvl(1, 1'b1, n);
      chk_rng("b_delay", 16, 24, n);
      wr(4'h0, 8'h7F);
      pwm_raw <= 1'b1;
      hi = 1'b0;
      repeat (100) begin
         @(posedge core_clk);
         hi = hi | pwm_out_val_ff[0];
      end
      chk("a_long", 8'h00, hi);
      pwm_raw <= 1'b0;
      wr(4'h0, 8'h80);
      for (int s = 0; s < 8; s++) begin
         for (int c = 0; c < 3; c++) begin
            wr(4'h4, {1'b0, s[2:0], 4'h0});
            pstart();
            cause(c, 1'b1);
            cyc(8);
            rdchk("status_set", 4'h4, 8'h80, {s[c], 7'h00});
            if (s[c]) chk("shut_pins", 8'hF0, {pwm_out_oe_ff, pwm_out_val_ff});
            cause(c, 1'b0);
            cyc(8);
            rdchk("auto_clear", 4'h4, 8'h80, 8'h00);
         end
      end
      chk("wait_period", 8'hF0, {pwm_out_oe_ff, pwm_out_val_ff});
      pstart();
      cyc(6);
      chk("resumed", 8'h01, pwm_out_val_ff[1]);
      for (int s = 0; s < 4; s++) begin
         ac = s;
         bd = s ^ 1;
         wr(4'h4, {4'b0100, ac[1:0], bd[1:0]});
         cause(2, 1'b1);
         cyc(8);
         chk("shut_oe", {4'h0, !bd[1], !ac[1], !bd[1], !ac[1]}, pwm_out_oe_ff);
         chk("shut_lvl", {4'h0, bd == 1, ac == 1, bd == 1, ac == 1}, pin_lvl);
         cause(2, 1'b0);
         cyc(8);
         pstart();
      end
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h10);
      cause(0, 1'b1);
      cyc(8);
      cause(0, 1'b0);
      cyc(8);
      rdchk("manual_hold", 4'h4, 8'h80, 8'h80);
      cause(0, 1'b1);
      cyc(8);
      wr(4'h4, 8'h10);
      rdchk("wr_ignored", 4'h4, 8'h80, 8'h80);
      cause(0, 1'b0);
      cyc(8);
      wr(4'h4, 8'h10);
      rdchk("sw_clear", 4'h4, 8'h80, 8'h00);
      chk("clr_wait", 8'hF0, {pwm_out_oe_ff, pwm_out_val_ff});
      pstart();
      wr(4'h4, 8'h90);
      cyc(4);
      rdchk("forced", 4'h4, 8'h80, 8'h80);
      chk("forced_pins", 8'hF0, {pwm_out_oe_ff, pwm_out_val_ff});
      wr(4'h4, 8'h10);
      pstart();
      // polarity flips make both pins high legally, so the short watch is switched off for the rest of the test
      watch_en = 1'b0;
      pwm_raw <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         wr(4'h8, {6'b000001, p[1:0]});
         cyc(8);
         chk("polarity", {6'h00, p[1], !p[0]}, pwm_out_val_ff[1:0]);
      end
      pwm_raw <= 1'b0;
      wr(4'h8, 8'h04);
      wr(4'h0, 8'h85);
      wr(4'h4, 8'h25);
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      rdchk("delay_kept", 4'h0, 8'hFF, 8'h85);
      rdchk("shut_clr", 4'h4, 8'hFF, 8'h00);
      srst <= 1'b1;
      por <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      por <= 1'b0;
      rdchk("delay_por", 4'h0, 8'hFF, 8'h00);
      chk("shoot", 8'h00, shoot_seen);
      wrap_up();
   end
endmodule
